// ==== core/qdsl_regs.svh ====
// Constants of the quad converter serial load control
`ifndef QDSL_REGS_SVH
`define QDSL_REGS_SVH
`define QDSL_WORD_W 16
`define QDSL_CODE_W 12
`define QDSL_ADDR_HI 15
`define QDSL_ADDR_LO 14
`define QDSL_CODE_MSB 11
`define QDSL_CODE_LSB 0
`define QDSL_MIDSCALE 12'h800
`define QDSL_ZEROSCALE 12'h000
`define QDSL_WORD_RST 16'h0000
`define QDSL_NCHAN 4
`define QDSL_PIN_IDLE 5'h1B
`endif

// ==== core/qdsl_pkg.sv ====
// Types of the quad converter serial load control
`include "qdsl_regs.svh"
package qdsl_pkg;
   typedef logic [`QDSL_CODE_W-1:0] qdsl_code_t;
   typedef struct packed {
      logic chan_addr_hi;
      logic chan_addr_lo;
      logic [1:0] fill;
      qdsl_code_t code;
   } qdsl_word_t;
   typedef struct packed {
      qdsl_code_t chan_d;
      qdsl_code_t chan_c;
      qdsl_code_t chan_b;
      qdsl_code_t chan_a;
   } qdsl_chans_t;
   typedef enum logic [1:0] {
      QDSL_CHAN_A = 2'h0,
      QDSL_CHAN_B = 2'h1,
      QDSL_CHAN_C = 2'h2,
      QDSL_CHAN_D = 2'h3
   } qdsl_chan_t;
   typedef struct packed {
      logic sclk;
      logic csn;
      logic data;
      logic ldn;
      logic clrn;
   } qdsl_pins_t;
endpackage

// ==== core/qdsl_sync.sv ====
// Two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module qdsl_sync #(
   parameter int WIDTH = 5,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_sync
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // Refuse an empty bus
   if (WIDTH < 1) begin
      $error("qdsl_sync: WIDTH must be positive");
   end

   // Two flops per pin, reset to the idle level of each pin
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= pin_in;
         sync_ff <= meta_ff;
      end
   end

   assign pin_sync = sync_ff;
endmodule

// ==== core/qdsl_top.sv ====
// Serial load control of a quad twelve-bit converter
`timescale 1ns/1ps
`include "qdsl_regs.svh"
module qdsl_top #(
   parameter int WORD_W = `QDSL_WORD_W,
   parameter int CODE_W = `QDSL_CODE_W
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic serial_clk,
   input wire logic chip_select_n,
   input wire logic serial_data_in,
   input wire logic load_strobe_n,
   input wire logic async_clear_n,
   input wire logic clear_value_select,
   output qdsl_pkg::qdsl_word_t shift_word,
   output qdsl_pkg::qdsl_chans_t chan_codes,
   output logic load_active
);

   // Raw and synchronised control pins
   qdsl_pkg::qdsl_pins_t pins_raw;
   qdsl_pkg::qdsl_pins_t pins_s;

   // Synchronised pin levels, split out by name
   logic sclk_s;
   logic csn_s;
   logic data_s;
   logic ldn_s;
   logic clrn_s;

   // Clear select level through its own two flops
   logic csel_meta_ff;
   logic csel_ff;

   // Edge history of the gated clock and the load strobe
   logic shclk_ff;
   logic ldn_ff;

   // Decoded shift and load events
   logic shift_clk;
   logic shift_rise;
   logic load_fall;
   logic load_low;
   logic take_word;

   // Serial-to-parallel shift register
   qdsl_pkg::qdsl_word_t word_ff;
   qdsl_pkg::qdsl_word_t nxt_word;

   // Clear request and the code it forces
   logic clear_on;
   qdsl_pkg::qdsl_code_t clear_code;

   // Channel address decode
   qdsl_pkg::qdsl_chan_t sel_chan;
   logic hit_a;
   logic hit_b;
   logic hit_c;
   logic hit_d;

   // Channel bank and load status
   qdsl_pkg::qdsl_code_t nxt_code_a;
   qdsl_pkg::qdsl_code_t nxt_code_b;
   qdsl_pkg::qdsl_code_t nxt_code_c;
   qdsl_pkg::qdsl_code_t nxt_code_d;
   qdsl_pkg::qdsl_chans_t nxt_chans;
   qdsl_pkg::qdsl_chans_t chans_ff;
   logic load_active_ff;

   // Refuse layouts the fixed field map cannot serve
   if (WORD_W != `QDSL_WORD_W) begin
      $error("qdsl_top: WORD_W must equal the word width");
   end
   if (CODE_W != `QDSL_CODE_W) begin
      $error("qdsl_top: CODE_W must equal the code width");
   end
   if ($bits(qdsl_pkg::qdsl_word_t) != WORD_W) begin
      $error("qdsl_top: word type disagrees with WORD_W");
   end
   if ($bits(qdsl_pkg::qdsl_code_t) != CODE_W) begin
      $error("qdsl_top: code type disagrees with CODE_W");
   end
   if ($bits(qdsl_pkg::qdsl_chans_t) != `QDSL_NCHAN * CODE_W) begin
      $error("qdsl_top: channel bank must hold four codes");
   end

   // True when the shifted address names the given channel
   function automatic logic chan_hit(
      input qdsl_pkg::qdsl_chan_t sel,
      input qdsl_pkg::qdsl_chan_t ch);
      return sel == ch;
   endfunction

   // Next code of one channel: clear wins, then load, else hold
   function automatic qdsl_pkg::qdsl_code_t next_code(
      input qdsl_pkg::qdsl_code_t cur,
      input logic hit,
      input logic clr,
      input logic take,
      input qdsl_pkg::qdsl_code_t code,
      input qdsl_pkg::qdsl_code_t clr_code);
      qdsl_pkg::qdsl_code_t r;
      r = cur;
      if (clr) begin
         r = clr_code;
      end else if (take && hit) begin
         r = code;
      end
      return r;
   endfunction

   // Gather the pins; clock, select, load and clear idle high
   assign pins_raw = '{sclk: serial_clk,
                       csn: chip_select_n,
                       data: serial_data_in,
                       ldn: load_strobe_n,
                       clrn: async_clear_n};

   // Two flops per pin, reset to the idle levels
   qdsl_sync #(
      .WIDTH($bits(qdsl_pkg::qdsl_pins_t)),
      .RST_VAL(`QDSL_PIN_IDLE)
   ) u_sync (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .pin_in(pins_raw),
      .pin_sync(pins_s)
   );

   // Name the synchronised levels
   assign sclk_s = pins_s.sclk;
   assign csn_s = pins_s.csn;
   assign data_s = pins_s.data;
   assign ldn_s = pins_s.ldn;
   assign clrn_s = pins_s.clrn;

   // Clear select is a level, read through two flops
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         csel_meta_ff <= 1'b0;
         csel_ff <= 1'b0;
      end else begin
         csel_meta_ff <= clear_value_select;
         csel_ff <= csel_meta_ff;
      end
   end

   // Gated shift clock; any rise of the OR shifts one bit
   assign shift_clk = sclk_s | csn_s;
   assign shift_rise = shift_clk & ~shclk_ff;

   // Shift register takes the data level MSB first
   assign nxt_word = shift_rise
      ? qdsl_pkg::qdsl_word_t'({word_ff[`QDSL_WORD_W-2:0], data_s})
      : word_ff;

   // Load strobe edge and low level; low keeps the bank transparent
   assign load_fall = ~ldn_s & ldn_ff;
   assign load_low = ~ldn_s;
   assign take_word = load_fall | load_low;

   // Clear request and the forced code
   assign clear_on = ~clrn_s;
   assign clear_code = csel_ff ? `QDSL_MIDSCALE
                               : `QDSL_ZEROSCALE;

   // Decode the two address bits into one channel
   assign sel_chan = qdsl_pkg::qdsl_chan_t'({word_ff.chan_addr_hi,
                        word_ff.chan_addr_lo});
   assign hit_a = chan_hit(sel_chan, qdsl_pkg::QDSL_CHAN_A);
   assign hit_b = chan_hit(sel_chan, qdsl_pkg::QDSL_CHAN_B);
   assign hit_c = chan_hit(sel_chan, qdsl_pkg::QDSL_CHAN_C);
   assign hit_d = chan_hit(sel_chan, qdsl_pkg::QDSL_CHAN_D);

   // Next code of each channel from the low twelve bits
   assign nxt_code_a = next_code(chans_ff.chan_a, hit_a, clear_on,
                                 take_word, word_ff.code,
                                 clear_code);
   assign nxt_code_b = next_code(chans_ff.chan_b, hit_b, clear_on,
                                 take_word, word_ff.code,
                                 clear_code);
   assign nxt_code_c = next_code(chans_ff.chan_c, hit_c, clear_on,
                                 take_word, word_ff.code,
                                 clear_code);
   assign nxt_code_d = next_code(chans_ff.chan_d, hit_d, clear_on,
                                 take_word, word_ff.code,
                                 clear_code);
   assign nxt_chans = qdsl_pkg::qdsl_chans_t'({nxt_code_d, nxt_code_c,
                                               nxt_code_b, nxt_code_a});

   // Edge history of the gated clock and the load strobe
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         shclk_ff <= 1'b1;
         ldn_ff <= 1'b1;
      end else begin
         shclk_ff <= shift_clk;
         ldn_ff <= ldn_s;
      end
   end

   // Shift register is never touched by clear
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         word_ff <= `QDSL_WORD_RST;
      end else begin
         word_ff <= nxt_word;
      end
   end

   // Channel registers and load status
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         chans_ff <= '0;
         load_active_ff <= 1'b0;
      end else begin
         chans_ff <= nxt_chans;
         load_active_ff <= load_low;
      end
   end

   assign shift_word = word_ff;
   assign chan_codes = chans_ff;
   assign load_active = load_active_ff;
endmodule

// ==== sim/qdsl_properties.sv ====
// Port checker of the serial load control
`timescale 1ns/1ps
module qdsl_properties (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic serial_clk,
   input wire logic chip_select_n,
   input wire logic serial_data_in,
   input wire logic load_strobe_n,
   input wire logic async_clear_n,
   input wire logic clear_value_select,
   input qdsl_pkg::qdsl_word_t shift_word,
   input qdsl_pkg::qdsl_chans_t chan_codes,
   input wire logic load_active
);
   // Gated shift clock and addressed channel
   wire logic sck = serial_clk | chip_select_n;
   wire logic [11:0] sel = chan_codes[12*shift_word[15:14] +: 12];
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // Shift, load and clear relations
   a_idle_no_shift: assert property (
      sck[*6] |-> $stable(shift_word)) else $error("idle shift");
   a_shift_takes_bit: assert property (
      $rose(sck) |-> ##[2:5] shift_word[0] == serial_data_in)
      else $error("bit lost");
   a_clear_value: assert property (
      (!async_clear_n && $stable(clear_value_select))[*5] |->
      chan_codes == {4{clear_value_select ? 12'h800 : 12'h000}})
      else $error("clear code");
   a_clear_keeps_word: assert property (
      (!async_clear_n && sck)[*6] |-> $stable(shift_word))
      else $error("clear hit word");
   a_load_follows: assert property (
      (load_active && async_clear_n)[*4] |-> sel == shift_word.code)
      else $error("load code");
   a_load_seen: assert property (
      $fell(load_strobe_n) |-> ##[2:4] load_active) else $error("no load");
   a_no_load_idle: assert property (
      load_strobe_n[*5] |-> !load_active) else $error("stray load");
   a_hold_value: assert property (
      (load_strobe_n && async_clear_n)[*6] |-> $stable(chan_codes))
      else $error("channel moved");
   c_shift: cover property ($rose(sck));
   c_load: cover property ($fell(load_strobe_n));
   c_mid: cover property (!async_clear_n && clear_value_select);
endmodule

// ==== sim/qdsl_host.sv ====
// Host model driving the serial pins
`timescale 1ns/1ps
module qdsl_host (
   input wire logic core_clk,
   output logic serial_clk = 1'b1,
   output logic chip_select_n = 1'b1,
   output logic serial_data_in = 1'b0,
   output logic load_strobe_n = 1'b1
);
   // Half of the 160 ns serial period
   task automatic half();
      repeat (16) @(posedge core_clk);
   endtask
   // Word MSB first; odd ends with a false edge
   task automatic send(input logic [15:0] w, input logic odd);
      chip_select_n <= 1'b0;
      half();
      for (int i = 15; i >= 0; i--) begin
         serial_clk <= 1'b0;
         serial_data_in <= w[i];
         half();
         serial_clk <= 1'b1;
         half();
      end
      serial_clk <= !odd;
      half();
      chip_select_n <= 1'b1;
      half();
      serial_data_in <= ~serial_data_in;
      serial_clk <= 1'b1;
   endtask
   // Load pulse, word held meanwhile
   task automatic load();
      load_strobe_n <= 1'b0;
      half();
      load_strobe_n <= 1'b1;
      half();
   endtask
endmodule

// ==== sim/quad_dac_serial_load_control_tb_top.sv ====
// Self-checking bench of the serial load control
`timescale 1ns/1ps
module quad_dac_serial_load_control_tb_top;
   logic core_clk, arst_n, async_clear_n, clear_value_select, load_active;
   logic serial_clk, chip_select_n, serial_data_in, load_strobe_n;
   qdsl_pkg::qdsl_word_t shift_word;
   qdsl_pkg::qdsl_chans_t chan_codes;
   int mismatches, checks_done;
   // Design and host model
   qdsl_top i_dut (.core_clk, .arst_n, .serial_clk, .chip_select_n,
      .serial_data_in, .load_strobe_n, .async_clear_n, .clear_value_select,
      .shift_word, .chan_codes, .load_active);
   qdsl_host i_host (.core_clk, .serial_clk, .chip_select_n,
      .serial_data_in, .load_strobe_n);
   // Clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic chk(input string n, input logic [47:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic complete_run();
      if (mismatches == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Each channel loaded in turn
   task automatic t_loads();
      logic [15:0] w;
      logic [47:0] e;
      e = 48'h0;
      for (int c = 0; c < 4; c++) begin
         w = {c[1:0], 2'h3, 12'(12'hA5C ^ (c * 12'h111))};
         i_host.send(w, 1'b0);
         chk("word", 48'(shift_word), 48'(w));
         i_host.load();
         e[12*c +: 12] = w[11:0];
         chk("chans", chan_codes, e);
      end
   endtask
   // Select rising with clock low
   task automatic t_false_edge();
      i_host.send(16'h8001, 1'b1);
      chk("false edge", 48'(shift_word), 48'h3);
   endtask
   // Clear to both values, then reload
   task automatic t_clear();
      logic [11:0] v;
      for (int s = 0; s < 2; s++) begin
         v = s[0] ? 12'h800 : 12'h000;
         clear_value_select <= s[0];
         async_clear_n <= 1'b0;
         i_host.half();
         chk("clear", chan_codes, {4{v}});
         chk("kept", 48'(shift_word), 48'h3);
         async_clear_n <= 1'b1;
         i_host.half();
         chk("held", chan_codes, {4{v}});
      end
      fork
         i_host.load();
         begin
            repeat (8) @(posedge core_clk);
            chk("active", 48'(load_active), 48'h1);
            chk("follow", chan_codes, {36'h800800800, 12'h003});
         end
      join
      chk("idle", 48'(load_active), 48'h0);
      chk("reload", chan_codes, {36'h800800800, 12'h003});
   endtask
   // Main sequence
   initial begin
      arst_n = 1'b0;
      async_clear_n = 1'b1;
      clear_value_select = 1'b0;
      mismatches = 0;
      checks_done = 0;
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      t_loads();
      t_false_edge();
      t_clear();
      complete_run();
   end
   // Watchdog
   initial begin
      repeat (10000) @(posedge core_clk);
      mismatches++;
      complete_run();
   end
endmodule
bind qdsl_top qdsl_properties i_chk (.core_clk, .arst_n, .serial_clk,
   .chip_select_n, .serial_data_in, .load_strobe_n, .async_clear_n,
   .clear_value_select, .shift_word, .chan_codes, .load_active);
